// File: verilog/drive_cmd_pkg.sv
// constants of the drive command logic: control bits, status bits, speed limits, timing
// assumes a 25 MHz ref_clk and a cyclic process-data word source
`default_nettype none

package drive_cmd_pkg;

	// ****************************************
	// control word bit positions
	// ****************************************
	localparam int CB_JOG_UP = 0;
	localparam int CB_JOG_DOWN = 1;
	localparam int CB_LOAD_TARGET = 2;
	localparam int CB_RELEASE = 4;
	localparam int CB_LOOP_FREE = 6;
	localparam int CB_READJUST = 10;
	localparam int CB_CLEAR_ERR = 14;

	// ****************************************
	// status word bit positions
	// ****************************************
	localparam int SB_IN_POS = 0;
	localparam int SB_POWER_OK = 4;
	localparam int SB_POS_ERR = 10;
	localparam int SB_DISPLACED = 11;
	localparam int SB_BAD_TARGET = 12;
	localparam int SB_POWER_MISS = 13;

	// ****************************************
	// speed validity and blocking
	// ****************************************
	localparam logic signed [15:0] SPEED_MIN_OK = 16'sh000A;
	localparam logic signed [15:0] SPEED_MAX_OK = 16'sh0050;
	localparam int BLOCK_PCT = 30;
	localparam int PCT_FULL = 100;
	localparam int BLOCK_TIME_MS = 200;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {ST_IDLE, ST_LOOP, ST_POS, ST_JOG, ST_HOLD} run_state_e;

endpackage

`default_nettype wire

// File: verilog/block_detect.sv
// blocking detector: flags a run whose achieved speed stays too low
// assumes a one-cycle millisecond enable from the caller
`default_nettype none
`timescale 1ns/100ps

module block_detect
	import drive_cmd_pkg::*;
#(
	parameter int SPD_W = 16,
	parameter int BLOCK_MS = BLOCK_TIME_MS
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ms_tick,
	input wire logic moving,
	input wire logic [SPD_W-1:0] achieved,
	input wire logic [SPD_W-1:0] sel_max,
	output logic blocked
);

	logic [15:0] low_ms;
	logic [15:0] next_low_ms;
	logic next_blocked;
	logic speed_low;

	// ****************************************
	// low-speed time counter
	// ****************************************
	always_comb
	begin
		speed_low = (32'(achieved) * 32'(PCT_FULL)) < (32'(sel_max) * 32'(BLOCK_PCT));
		next_low_ms = low_ms;
		next_blocked = 1'b0;
		if (!moving || !speed_low)
		begin
			next_low_ms = 16'h0000;
		end
		else if (ms_tick)
		begin
			if (low_ms >= 16'(BLOCK_MS))
			begin
				next_blocked = 1'b1;
				next_low_ms = 16'h0000;
			end
			else
			begin
				next_low_ms = low_ms + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			low_ms <= 16'h0000;
			blocked <= 1'b0;
		end
		else
		begin
			low_ms <= next_low_ms;
			blocked <= next_blocked;
		end
	end

	a_block_needs_low: assert property (@(posedge ref_clk) disable iff (rst)
		blocked |-> $past(moving) && $past(low_ms) == 16'(BLOCK_MS))
		else $error("block flagged without full low-speed time");

endmodule

`default_nettype wire

// File: verilog/drive_command_control.sv
// command and supervision logic of a positioning drive fed by cyclic process data
// assumes a motion unit that follows drive_target / jog outputs and reports back
`default_nettype none
`timescale 1ns/100ps

// Summary of operation
// - value 0x14 with a target starts a positioning run at once
// - value 0x00 drops release and cancels any positioning or jog
// - a new target mid-run redirects at once, without stopping
// - jog command during positioning aborts it and continues as slow jog
// - 0x04 loads a target without release; a later 0x10 starts the run
// - bit 6 with release requests a loop-free direct approach
// - 0x11 or 0x12 jogs; 0x10 or 0x00 stops the jog
// - a differing target received while jogging ends the jog and approaches it
// - eight-byte speed field applies immediately, also mid-run
// - nonzero process speed overrides stored speeds; zero selects them
// - invalid speed blocks starts, aborts motion, sets status bit 12
// - effective speed is limited by the clockwise or counterclockwise maximum
// - jogs use manual speed, positioning uses positioning speed
// - start-up torque limit holds for a set time after each start
// - speed below 30% of maximum over 200 ms: block, error, hold
// - after a block a differing target starts a fresh run
// - pushed against loop after a good run: readjust, set bit 0 again
// - pushed in loop direction: set bit 11, clear bit 0; loop-free both
// - readjust only with motor power, else set bits 10 and 13
// - release drop disables readjust until release returns; dropped mid-run, until a run completes correctly
// - looped targets behind the shaft are overshot by loop length first
// - rising bit 14 clears error bits 10, 11, 12, 13
module drive_command_control
	import drive_cmd_pkg::*;
#(
	parameter int POS_W = 32,
	parameter int SPD_W = 16,
	parameter int MS_CYCLES = MS_CYCLES_DEF,
	parameter int BLOCK_MS = BLOCK_TIME_MS
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic operate,
	input wire logic pd_valid,
	input wire logic eight_byte,
	input wire logic [15:0] ctrl,
	input wire logic [POS_W-1:0] pd_target,
	input wire logic signed [SPD_W-1:0] pd_speed,
	input wire logic [SPD_W-1:0] posi_speed,
	input wire logic [SPD_W-1:0] manual_speed,
	input wire logic [SPD_W-1:0] max_ccw,
	input wire logic [SPD_W-1:0] max_cw,
	input wire logic [SPD_W-1:0] sel_max,
	input wire logic [POS_W-1:0] loop_len,
	input wire logic [15:0] startup_ms,
	input wire logic [POS_W-1:0] actual_pos,
	input wire logic [SPD_W-1:0] actual_speed,
	input wire logic move_done,
	input wire logic in_window,
	input wire logic motor_power_ok,
	output logic drive_en,
	output logic [POS_W-1:0] drive_target,
	output logic jog_active,
	output logic jog_up,
	output logic [SPD_W-1:0] speed_cmd,
	output logic startup_torque,
	output logic hold_torque,
	output logic [15:0] status_word
);

	function automatic logic [SPD_W-1:0] min_speed(input logic [SPD_W-1:0] a, input logic [SPD_W-1:0] b);
		min_speed = (a < b) ? a : b;
	endfunction

	run_state_e state, next_state;
	logic [POS_W-1:0] tgt, next_tgt;
	logic signed [SPD_W-1:0] spd_pd, next_spd_pd;
	logic pend, next_pend;
	logic rel_lvl, next_rel_lvl;
	logic readj_lvl, next_readj_lvl;
	logic loop_free, next_loop_free;
	logic clr_prev, next_clr_prev;
	logic done_ok, next_done_ok;
	logic in_pos, next_in_pos;
	logic pos_err, next_pos_err;
	logic displaced, next_displaced;
	logic bad_tgt, next_bad_tgt;
	logic pwr_miss, next_pwr_miss;
	logic next_jog_up, jog_dir;
	logic [POS_W-1:0] next_drive_target;
	logic [SPD_W-1:0] next_speed_cmd;
	logic [SPD_W-1:0] req_speed;
	logic [15:0] su_cnt, next_su_cnt;
	logic [31:0] ms_cnt, next_ms_cnt;
	logic ms_tick, next_ms_tick;
	logic cmd, rel, load, jog_cmd, spd_bad, moving, next_moving;
	logic readj_try, blk;

	// ****************************************
	// millisecond enable
	// ****************************************
	always_comb
	begin
		next_ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
		next_ms_cnt = next_ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ms_cnt <= 32'h0000_0000;
			ms_tick <= 1'b0;
		end
		else
		begin
			ms_cnt <= next_ms_cnt;
			ms_tick <= next_ms_tick;
		end
	end

	block_detect #(.SPD_W(SPD_W), .BLOCK_MS(BLOCK_MS)) u_block (
		.ref_clk(ref_clk),
		.rst(rst),
		.ms_tick(ms_tick),
		.moving(moving),
		.achieved(actual_speed),
		.sel_max(sel_max),
		.blocked(blk)
	);

	// ****************************************
	// command decode and run sequencing
	// ****************************************
	always_comb
	begin
		cmd = operate && pd_valid;
		rel = ctrl[CB_RELEASE];
		load = ctrl[CB_LOAD_TARGET];
		jog_cmd = ctrl[CB_JOG_UP] ^ ctrl[CB_JOG_DOWN];
		spd_bad = eight_byte && (pd_speed < 0 || (pd_speed != 0 && pd_speed < SPEED_MIN_OK)
			|| pd_speed > SPEED_MAX_OK);
		moving = (state == ST_LOOP) || (state == ST_POS) || (state == ST_JOG);
		next_state = state;
		next_tgt = tgt;
		next_spd_pd = spd_pd;
		next_pend = pend;
		next_rel_lvl = rel_lvl;
		next_readj_lvl = readj_lvl;
		next_loop_free = loop_free;
		next_clr_prev = clr_prev;
		next_done_ok = done_ok;
		next_in_pos = in_pos;
		next_pos_err = pos_err;
		next_displaced = displaced;
		next_bad_tgt = bad_tgt;
		next_pwr_miss = pwr_miss;
		jog_dir = jog_up;
		readj_try = 1'b0;
		if (cmd)
		begin
			if (ctrl[CB_CLEAR_ERR] && !clr_prev)
			begin
				next_pos_err = 1'b0;
				next_displaced = 1'b0;
				next_bad_tgt = 1'b0;
				next_pwr_miss = 1'b0;
			end
			next_spd_pd = pd_speed;
			next_loop_free = ctrl[CB_LOOP_FREE];
			next_readj_lvl = ctrl[CB_READJUST];
			if (spd_bad)
			begin
				next_bad_tgt = 1'b1;
				if (moving)
				begin
					next_state = ST_IDLE;
					next_done_ok = 1'b0;
				end
			end
			else if (!rel)
			begin
				if (moving)
				begin
					next_state = ST_IDLE;
					next_done_ok = 1'b0;
				end
				if (load)
				begin
					next_tgt = pd_target;
					next_pend = 1'b1;
				end
			end
			else if (jog_cmd)
			begin
				next_state = ST_JOG;
				jog_dir = ctrl[CB_JOG_UP];
				next_in_pos = 1'b0;
				next_done_ok = 1'b0;
			end
			else if ((load && (pd_target != tgt || !rel_lvl)) || (!rel_lvl && pend))
			begin
				if (load)
				begin
					next_tgt = pd_target;
				end
				next_pend = 1'b0;
				next_in_pos = 1'b0;
				next_done_ok = 1'b0;
				next_state = (!ctrl[CB_LOOP_FREE] && (load ? pd_target : tgt) < actual_pos) ? ST_LOOP : ST_POS;
			end
			else if (state == ST_JOG)
			begin
				next_state = ST_IDLE;
			end
			next_rel_lvl = rel;
			next_clr_prev = ctrl[CB_CLEAR_ERR];
		end
		else if (move_done && state == ST_LOOP)
		begin
			next_state = ST_POS;
		end
		else if (move_done && state == ST_POS)
		begin
			next_state = ST_IDLE;
			next_in_pos = 1'b1;
			next_done_ok = 1'b1;
			next_displaced = 1'b0;
		end
		else if (state == ST_IDLE && done_ok && !in_window)
		begin
			next_in_pos = 1'b0;
			if (rel_lvl && readj_lvl && (actual_pos < tgt || loop_free))
			begin
				readj_try = 1'b1;
				if (motor_power_ok)
				begin
					next_state = ST_POS;
				end
				else
				begin
					next_pos_err = 1'b1;
					next_pwr_miss = 1'b1;
					next_done_ok = 1'b0;
				end
			end
			else
			begin
				next_displaced = 1'b1;
			end
		end
		if (blk && moving)
		begin
			next_state = ST_HOLD;
			next_pos_err = 1'b1;
			next_done_ok = 1'b0;
		end
	end

	// ****************************************
	// drive outputs: target, speed, torque
	// ****************************************
	always_comb
	begin
		next_moving = (next_state == ST_LOOP) || (next_state == ST_POS) || (next_state == ST_JOG);
		next_drive_target = (next_state == ST_LOOP) ? next_tgt - loop_len : next_tgt;
		next_jog_up = jog_dir;
		if (next_state != ST_JOG && next_moving)
		begin
			next_jog_up = next_drive_target > actual_pos;
		end
		req_speed = (next_state == ST_JOG) ? manual_speed : posi_speed;
		if (eight_byte && next_spd_pd != 0)
		begin
			req_speed = SPD_W'(next_spd_pd);
		end
		next_speed_cmd = min_speed(req_speed, next_jog_up ? max_cw : max_ccw);
		next_su_cnt = su_cnt;
		if (next_moving && !moving)
		begin
			next_su_cnt = startup_ms;
		end
		else if (!next_moving)
		begin
			next_su_cnt = 16'h0000;
		end
		else if (ms_tick && su_cnt != 16'h0000)
		begin
			next_su_cnt = su_cnt - 16'h0001;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			tgt <= '0;
			spd_pd <= '0;
			pend <= 1'b0;
			rel_lvl <= 1'b0;
			readj_lvl <= 1'b0;
			loop_free <= 1'b0;
			clr_prev <= 1'b0;
			done_ok <= 1'b0;
			in_pos <= 1'b0;
			pos_err <= 1'b0;
			displaced <= 1'b0;
			bad_tgt <= 1'b0;
			pwr_miss <= 1'b0;
			su_cnt <= 16'h0000;
			drive_en <= 1'b0;
			drive_target <= '0;
			jog_active <= 1'b0;
			jog_up <= 1'b0;
			speed_cmd <= '0;
			startup_torque <= 1'b0;
			hold_torque <= 1'b0;
			status_word <= 16'h0000;
		end
		else
		begin
			state <= next_state;
			tgt <= next_tgt;
			spd_pd <= next_spd_pd;
			pend <= next_pend;
			rel_lvl <= next_rel_lvl;
			readj_lvl <= next_readj_lvl;
			loop_free <= next_loop_free;
			clr_prev <= next_clr_prev;
			done_ok <= next_done_ok;
			in_pos <= next_in_pos;
			pos_err <= next_pos_err;
			displaced <= next_displaced;
			bad_tgt <= next_bad_tgt;
			pwr_miss <= next_pwr_miss;
			su_cnt <= next_su_cnt;
			drive_en <= next_moving;
			drive_target <= next_drive_target;
			jog_active <= (next_state == ST_JOG);
			jog_up <= next_jog_up;
			speed_cmd <= next_speed_cmd;
			startup_torque <= next_su_cnt != 16'h0000;
			hold_torque <= (next_state == ST_HOLD);
			status_word <= 16'h0000;
			status_word[SB_IN_POS] <= next_in_pos;
			status_word[SB_POWER_OK] <= motor_power_ok;
			status_word[SB_POS_ERR] <= next_pos_err;
			status_word[SB_DISPLACED] <= next_displaced;
			status_word[SB_BAD_TARGET] <= next_bad_tgt;
			status_word[SB_POWER_MISS] <= next_pwr_miss;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_offline_ignored: assert property (@(posedge ref_clk) disable iff (rst)
		!operate |=> !$rose(jog_active))
		else $error("jog started while link not operating");

	a_release_cancel: assert property (@(posedge ref_clk) disable iff (rst)
		cmd && !rel |=> !drive_en)
		else $error("motion continued after release drop");

	a_jog_start: assert property (@(posedge ref_clk) disable iff (rst)
		cmd && rel && jog_cmd && !spd_bad && !blk |=> jog_active && drive_en && jog_up == $past(ctrl[CB_JOG_UP]))
		else $error("jog command not followed");

	a_redirect_run: assert property (@(posedge ref_clk) disable iff (rst)
		cmd && rel && load && !jog_cmd && !spd_bad && !blk && state == ST_POS && pd_target != tgt
		&& (ctrl[CB_LOOP_FREE] || pd_target >= actual_pos)
		|=> drive_en && !jog_active && drive_target == $past(pd_target))
		else $error("new target not taken mid-run");

	a_redirect_loop: assert property (@(posedge ref_clk) disable iff (rst)
		cmd && rel && load && !jog_cmd && !spd_bad && !blk && state == ST_POS && pd_target != tgt
		&& !ctrl[CB_LOOP_FREE] && pd_target < actual_pos
		|=> drive_en && !jog_active && drive_target == $past(pd_target) - $past(loop_len))
		else $error("new target behind shaft not looped mid-run");

	a_bad_speed: assert property (@(posedge ref_clk) disable iff (rst)
		cmd && spd_bad && !moving |=> status_word[SB_BAD_TARGET] && !drive_en)
		else $error("invalid speed not rejected");

	a_startup_torque: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(drive_en) && $past(startup_ms) != 16'h0000 |-> startup_torque)
		else $error("start-up torque missing at travel start");

	a_block_hold: assert property (@(posedge ref_clk) disable iff (rst)
		blk && moving |=> hold_torque && status_word[SB_POS_ERR] && !drive_en)
		else $error("block not handled");

	a_done_in_pos: assert property (@(posedge ref_clk) disable iff (rst)
		move_done && state == ST_POS && !cmd && !blk |=> status_word[SB_IN_POS] && !drive_en)
		else $error("finished run not reported in position");

	a_readj_no_power: assert property (@(posedge ref_clk) disable iff (rst)
		readj_try && !motor_power_ok && !blk |=> status_word[SB_POWER_MISS] && status_word[SB_POS_ERR]
		&& !drive_en)
		else $error("readjust without motor power not flagged");

	a_error_clear: assert property (@(posedge ref_clk) disable iff (rst)
		cmd && ctrl[CB_CLEAR_ERR] && !clr_prev && !spd_bad && !blk && !readj_try
		|=> !status_word[SB_POS_ERR] && !status_word[SB_BAD_TARGET] && !status_word[SB_POWER_MISS]
		&& !status_word[SB_DISPLACED])
		else $error("error bits not cleared on bit 14 edge");

endmodule

`default_nettype wire

// File: tb/pd_master.sv
// link master stand-in: drives cyclic process-output words
// assumes the bench calls its tasks; one word per send
`timescale 1ns/100ps
`default_nettype none

module pd_master
(
	input wire logic ref_clk,
	output var logic operate,
	output var logic pd_valid,
	output var logic [15:0] ctrl,
	output var logic [31:0] pd_target,
	output var logic signed [15:0] pd_speed
);
	// ****************************************
	// link state and process words
	// ****************************************
	initial
	begin
		operate = 1'b0;
		pd_valid = 1'b0;
		ctrl = 16'h0000;
		pd_target = 32'h00000000;
		pd_speed = 16'sh0000;
	end

	task automatic go_operate();
		@(posedge ref_clk);
		operate <= 1'b1;
	endtask

	task automatic send(input logic [15:0] c, input logic [31:0] t, input logic signed [15:0] s);
		@(posedge ref_clk);
		pd_valid <= 1'b1;
		ctrl <= c;
		pd_target <= t;
		pd_speed <= s;
		@(posedge ref_clk);
		pd_valid <= 1'b0;
	endtask

	// same target after a block: drop release, then raise it with load
	task automatic retry(input logic [31:0] t);
		send(16'h0000, t, 16'sh0000);
		send(16'h0014, t, 16'sh0000);
	endtask
endmodule

`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench of the drive command logic
// assumes pd_master as word source; bench plays the motion unit
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import drive_cmd_pkg::*;
();
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic operate, pd_valid;
	logic [15:0] ctrl;
	logic [31:0] pd_target;
	logic signed [15:0] pd_speed;
	logic eight_byte = 1'b0;
	logic [15:0] posi_speed = 16'h0028;
	logic [15:0] manual_speed = 16'h0014;
	logic [15:0] max_ccw = 16'h000F;
	logic [15:0] max_cw = 16'h003C;
	logic [15:0] sel_max = 16'h0032;
	logic [15:0] startup_ms = 16'h0002;
	logic [15:0] actual_speed = 16'h0032;
	logic [31:0] loop_len = 32'h00000032;
	logic [31:0] actual_pos = 32'h00000064;
	logic move_done = 1'b0;
	logic in_window = 1'b1;
	logic motor_power_ok = 1'b1;
	logic drive_en, jog_active, jog_up, startup_torque, hold_torque;
	logic [31:0] drive_target;
	logic [15:0] speed_cmd, status_word;
	logic [15:0] good_spd [2] = '{16'h000A, 16'h0050};
	logic [15:0] good_exp [2] = '{16'h000A, 16'h003C};
	logic [15:0] bad_spd [4] = '{16'hFFFF, 16'h0001, 16'h0009, 16'h0051};
	int fail_count = 0;
	int checked = 0;

	always #20 ref_clk = ~ref_clk;

	pd_master u_pd_master (.ref_clk(ref_clk), .operate(operate), .pd_valid(pd_valid), .ctrl(ctrl),
		.pd_target(pd_target), .pd_speed(pd_speed));

	drive_command_control #(.MS_CYCLES(10), .BLOCK_MS(3)) u_drive_command_control (.ref_clk(ref_clk),
		.rst(rst), .operate(operate), .pd_valid(pd_valid), .eight_byte(eight_byte), .ctrl(ctrl),
		.pd_target(pd_target), .pd_speed(pd_speed), .posi_speed(posi_speed), .manual_speed(manual_speed),
		.max_ccw(max_ccw), .max_cw(max_cw), .sel_max(sel_max), .loop_len(loop_len), .startup_ms(startup_ms),
		.actual_pos(actual_pos), .actual_speed(actual_speed), .move_done(move_done), .in_window(in_window),
		.motor_power_ok(motor_power_ok), .drive_en(drive_en), .drive_target(drive_target),
		.jog_active(jog_active), .jog_up(jog_up), .speed_cmd(speed_cmd), .startup_torque(startup_torque),
		.hold_torque(hold_torque), .status_word(status_word));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: pick = drive_en;
			1: pick = hold_torque;
			default: pick = startup_torque;
		endcase
	endfunction

	task automatic wait_val(input int w, input logic v, input int lim);
		int i;
		for (i = 0; i < lim; i++)
		begin
			if (pick(w) === v)
				return;
			@(posedge ref_clk);
			#1;
		end
		fail_count++;
		$display("[FAIL] %0t wait ran out", $time);
		final_report();
	endtask

	task automatic tx(input logic [15:0] c, input logic [31:0] t, input logic signed [15:0] s);
		u_pd_master.send(c, t, s);
		@(posedge ref_clk);
		#1;
	endtask

	task automatic done_pulse(input logic [31:0] p);
		@(posedge ref_clk);
		move_done <= 1'b1;
		actual_pos <= p;
		in_window <= 1'b1;
		@(posedge ref_clk);
		move_done <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic setpos(input logic [31:0] p, input logic w);
		@(posedge ref_clk);
		actual_pos <= p;
		in_window <= w;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		int i;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk(drive_en, 1'b0);
		tx(16'h0014, 32'h000001F4, 16'sh0000);
		chk(drive_en, 1'b0);
		u_pd_master.go_operate();
		tx(16'h0014, 32'h000001F4, 16'sh0000);
		chk(drive_en, 1'b1);
		chk(drive_target, 32'h000001F4);
		chk(speed_cmd, 16'h0028);
		chk(startup_torque, 1'b1);
		chk(status_word[SB_IN_POS], 1'b0);
		tx(16'h0014, 32'h00000258, 16'sh0000);
		chk(drive_target, 32'h00000258);
		chk(drive_en, 1'b1);
		wait_val(2, 1'b0, 30);
		tx(16'h0011, 32'h00000258, 16'sh0000);
		chk(jog_active, 1'b1);
		chk(jog_up, 1'b1);
		chk(speed_cmd, 16'h0014);
		tx(16'h0010, 32'h00000258, 16'sh0000);
		chk(jog_active, 1'b0);
		chk(drive_en, 1'b0);
		tx(16'h0012, 32'h00000258, 16'sh0000);
		chk(jog_up, 1'b0);
		chk(speed_cmd, 16'h000F);
		tx(16'h0000, 32'h00000258, 16'sh0000);
		chk(drive_en, 1'b0);
		tx(16'h0011, 32'h00000258, 16'sh0000);
		tx(16'h0014, 32'h00000384, 16'sh0000);
		chk(jog_active, 1'b0);
		chk(drive_target, 32'h00000384);
		done_pulse(32'h00000384);
		chk(drive_en, 1'b0);
		chk(status_word[SB_IN_POS], 1'b1);
		tx(16'h0004, 32'h000004B0, 16'sh0000);
		chk(drive_en, 1'b0);
		tx(16'h0010, 32'h000004B0, 16'sh0000);
		chk(drive_target, 32'h000004B0);
		tx(16'h0000, 32'h000004B0, 16'sh0000);
		chk(drive_en, 1'b0);
		tx(16'h0014, 32'h0000012C, 16'sh0000);
		chk(drive_target, 32'h000000FA);
		done_pulse(32'h000000FA);
		chk(drive_target, 32'h0000012C);
		done_pulse(32'h0000012C);
		chk(drive_en, 1'b0);
		tx(16'h0054, 32'h00000064, 16'sh0000);
		chk(drive_target, 32'h00000064);
		done_pulse(32'h00000064);
		eight_byte <= 1'b1;
		tx(16'h0014, 32'h00000190, 16'sh001E);
		chk(speed_cmd, 16'h001E);
		tx(16'h0014, 32'h00000190, 16'sh0046);
		chk(speed_cmd, 16'h003C);
		tx(16'h0014, 32'h00000190, 16'sh0000);
		chk(speed_cmd, 16'h0028);
		for (i = 0; i < 4; i++)
		begin
			tx(16'h0014, 32'h00000800 + i, good_spd[i % 2]);
			chk(speed_cmd, good_exp[i % 2]);
			tx(16'h0014, 32'h00000800 + i, bad_spd[i]);
			chk(drive_en, 1'b0);
			chk(status_word[SB_BAD_TARGET], 1'b1);
		end
		tx(16'h4000, 32'h00000800, 16'sh0000);
		chk(status_word[SB_BAD_TARGET], 1'b0);
		eight_byte <= 1'b0;
		tx(16'h0014, 32'h000002BC, 16'sh0000);
		actual_speed <= 16'h0000;
		wait_val(1, 1'b1, 80);
		chk(drive_en, 1'b0);
		chk(status_word[SB_POS_ERR], 1'b1);
		actual_speed <= 16'h0032;
		tx(16'h0014, 32'h00000320, 16'sh0000);
		chk(drive_en, 1'b1);
		actual_speed <= 16'h0000;
		wait_val(1, 1'b1, 80);
		actual_speed <= 16'h0032;
		tx(16'h0014, 32'h00000320, 16'sh0000);
		chk(drive_en, 1'b0);
		u_pd_master.retry(32'h00000320);
		@(posedge ref_clk);
		#1;
		chk(drive_en, 1'b1);
		done_pulse(32'h00000320);
		tx(16'h4000, 32'h00000320, 16'sh0000);
		chk(status_word[SB_POS_ERR], 1'b0);
		tx(16'h0414, 32'h000003E8, 16'sh0000);
		done_pulse(32'h000003E8);
		setpos(32'h000003DE, 1'b0);
		chk(drive_en, 1'b1);
		chk(drive_target, 32'h000003E8);
		done_pulse(32'h000003E8);
		chk(status_word[SB_IN_POS], 1'b1);
		setpos(32'h000003F2, 1'b0);
		chk(status_word[SB_DISPLACED], 1'b1);
		chk(status_word[SB_IN_POS], 1'b0);
		chk(drive_en, 1'b0);
		setpos(32'h000003E8, 1'b1);
		tx(16'h4410, 32'h000003E8, 16'sh0000);
		chk(status_word[SB_DISPLACED], 1'b0);
		tx(16'h0414, 32'h000004B0, 16'sh0000);
		done_pulse(32'h000004B0);
		tx(16'h0400, 32'h000004B0, 16'sh0000);
		setpos(32'h000004A6, 1'b0);
		chk(drive_en, 1'b0);
		setpos(32'h000004B0, 1'b1);
		tx(16'h0414, 32'h00000514, 16'sh0000);
		done_pulse(32'h00000514);
		motor_power_ok <= 1'b0;
		setpos(32'h0000050A, 1'b0);
		chk(drive_en, 1'b0);
		chk(status_word[SB_POS_ERR], 1'b1);
		chk(status_word[SB_POWER_MISS], 1'b1);
		motor_power_ok <= 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		chk(drive_en, 1'b0);
		chk(status_word[SB_POWER_OK], 1'b1);
		final_report();
	end
endmodule

`default_nettype wire
